// File: include/charger_regs_pkg.sv
package charger_regs_pkg;
	// =====================================================================
	// register offsets
	localparam logic [7:0] CHG_CTL_OFS = 8'h0b;
	localparam logic [7:0] CTL_ONE_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h0d;
	localparam logic [7:0] FLAGS_OFS = 8'h0e;
	localparam logic [7:0] MASKS_OFS = 8'h0f;

	// =====================================================================
	// field positions
	localparam int REG_RST_BIT = 7;
	localparam int WDOG_EXPIRED_BIT = 3;
	localparam int CHARGE_ON_BIT = 7;
	localparam int ROLE_LSB = 5;
	localparam int FREQ_LSB = 3;
	localparam int BUS_PROT_BIT = 2;
	localparam int BATT_PROT_BIT = 1;
	localparam int DIE_PROT_BIT = 0;
	localparam int ADC_DONE_BIT = 0;

	// =====================================================================
	// values after reset and counts
	localparam logic [1:0] FREQ_NOMINAL = 2'h0;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [1:0] INIT_WAIT = 2'h2;
	localparam int ALARM_W = 5;
	localparam int ATTACH_W = 2;

	// role field: 00 standalone, 01 slave, 1x master
	typedef enum logic [1:0] {
		ROLE_ALONE = 2'h0,
		ROLE_SLAVE = 2'h1,
		ROLE_MASTER = 2'h2
	} role_t;

	typedef struct packed {
		logic charge_on;
		logic [1:0] freq_offset_sel;
		logic bus_thermistor_prot_off;
		logic batt_thermistor_prot_off;
		logic die_temp_prot_off;
	} ctl_one_t;

	localparam ctl_one_t CTL_RESET = '{1'b0, FREQ_NOMINAL, 1'b0, 1'b0, 1'b0};

	// register access strobe group
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// File: rtl/level_sync2.sv
`timescale 1ns/1ps
module level_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("level_sync2: WIDTH must be at least 1");
	end

	// first stage is read only by the second stage
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// File: rtl/charger_ctrl_alarm_irq_regs.sv
`timescale 1ns/1ps
// Function
// R1: bit 7 charge on; cleared by reset, watchdog
// R2: read-only role field, untouched by resets
// R3: two-bit frequency shift field, resets 00
// R4: bus thermistor disable, default 1 if master
// R5: battery thermistor disable, default 1 if master
// R6: bit 0 die protection disable, resets 0
// R7: alarm status bits follow live conditions
// R8: insertion status bits follow live thresholds
// R9: done clears on request or in continuous mode, sets on single-shot completion
// R10: alarm/insert flags sticky, cleared by read
// R11: done flag set only on single-shot completion
// R12: masks block alert; register reset only
// R13: alert held while any unmasked flag set
// R14: host reads flags after each alert
// R15: register reset restores resettable fields only
// R16: watchdog timeout sets flag, clears charge
module charger_ctrl_alarm_irq_regs (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// register access from the serial engine
	input charger_regs_pkg::reg_req_t req_i,
	output logic [7:0] reg_rdata_o,
	// analog comparators and role strap (asynchronous)
	input wire logic [charger_regs_pkg::ALARM_W-1:0] alarm_live_i,
	input wire logic [charger_regs_pkg::ATTACH_W-1:0] attach_live_i,
	input wire logic [1:0] role_select_i,
	// converter and watchdog events (same clock)
	input wire logic adc_oneshot_req_i,
	input wire logic adc_oneshot_done_i,
	input wire logic adc_continuous_i,
	input wire logic wdt_timeout_i,
	// control outputs
	output charger_regs_pkg::ctl_one_t ctl_o,
	output logic alert_b_o
);
	import charger_regs_pkg::*;

	localparam int SYNC_W = ALARM_W + ATTACH_W + 2;

	// =====================================================================
	// input synchronisers
	logic [SYNC_W-1:0] sync_w;
	level_sync2 #(.WIDTH(SYNC_W)) level_sync2_i (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.async_i({alarm_live_i, attach_live_i, role_select_i}),
		.sync_o(sync_w)
	);

	logic [ALARM_W+ATTACH_W-1:0] live_w;
	logic [1:0] role_w;
	assign live_w = sync_w[SYNC_W-1:2];
	assign role_w = sync_w[1:0];

	// =====================================================================
	// decode
	function automatic logic hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] ofs);
		return strobe && (addr == ofs);
	endfunction

	wire wr_ctl_w = hit(req_i.wr, req_i.addr, CHG_CTL_OFS);
	wire wr_one_w = hit(req_i.wr, req_i.addr, CTL_ONE_OFS);
	wire wr_mask_w = hit(req_i.wr, req_i.addr, MASKS_OFS);
	wire rd_flag_w = hit(req_i.rd, req_i.addr, FLAGS_OFS);
	wire rd_ctl_w = hit(req_i.rd, req_i.addr, CHG_CTL_OFS);
	wire regrst_w = wr_ctl_w && req_i.wdata[REG_RST_BIT];
	wire master_w = role_w[1];

	// =====================================================================
	// state
	ctl_one_t ctl_d;
	logic [7:0] mask_q, mask_d;
	logic [7:0] flag_q, flag_d, set_w;
	logic [ALARM_W+ATTACH_W-1:0] live_prev_q;
	logic done_q, done_d;
	logic watchdog_expired_flag_q, watchdog_expired_flag_d;
	logic [1:0] init_q, init_d;
	logic [7:0] rdata_d, status_w;
	logic alert_d;

	// strap is valid only after the synchroniser has filled, so load one cycle later;
	// a strap change after this is not reloaded until a register reset
	wire init_load_w = (init_q == INIT_WAIT);
	assign init_d = (init_q > INIT_WAIT) ? init_q : init_q + 2'h1;

	assign status_w = {live_w, done_q}; // [R7] [R8]

	// flag events: rising edge of a live condition, or single-shot end
	assign set_w = {live_w & ~live_prev_q, // [R10]
		adc_oneshot_done_i && !adc_continuous_i}; // [R11]
	// an event in the reading cycle survives the clear
	assign flag_d = set_w | (rd_flag_w ? FLAG_RESET : flag_q); // [R10]

	assign done_d = adc_continuous_i ? 1'b0 : // [R9]
		adc_oneshot_req_i ? 1'b0 :
		adc_oneshot_done_i ? 1'b1 : done_q;

	assign watchdog_expired_flag_d = wdt_timeout_i | (watchdog_expired_flag_q && !rd_ctl_w); // [R16]
	assign mask_d = regrst_w ? MASK_RESET : (wr_mask_w ? req_i.wdata : mask_q); // [R12] [R15]

	always_comb begin
		ctl_d = ctl_o;
		if (wr_one_w) begin
			ctl_d.charge_on = req_i.wdata[CHARGE_ON_BIT];
			ctl_d.freq_offset_sel = req_i.wdata[FREQ_LSB+:2];
			ctl_d.bus_thermistor_prot_off = req_i.wdata[BUS_PROT_BIT];
			ctl_d.batt_thermistor_prot_off = req_i.wdata[BATT_PROT_BIT];
			ctl_d.die_temp_prot_off = req_i.wdata[DIE_PROT_BIT];
		end
		if (regrst_w || init_load_w) begin
			ctl_d = CTL_RESET; // [R1] [R3] [R6] [R15]
			ctl_d.bus_thermistor_prot_off = master_w; // [R4]
			ctl_d.batt_thermistor_prot_off = master_w; // [R5]
		end
		if (wdt_timeout_i) begin
			ctl_d.charge_on = 1'b0; // [R1] [R16]
		end
	end

	// read mux; role reads straight from the strap, never stored
	always_comb begin
		rdata_d = 8'h00;
		case (req_i.addr)
			CHG_CTL_OFS: rdata_d[WDOG_EXPIRED_BIT] = watchdog_expired_flag_q;
			CTL_ONE_OFS: rdata_d = {ctl_o.charge_on, role_w, ctl_o.freq_offset_sel, // [R2]
				ctl_o.bus_thermistor_prot_off, ctl_o.batt_thermistor_prot_off,
				ctl_o.die_temp_prot_off};
			STATUS_OFS: rdata_d = status_w;
			FLAGS_OFS: rdata_d = flag_q;
			MASKS_OFS: rdata_d = mask_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// alert follows the next flag state so it drops right after the read
	assign alert_d = (|(flag_d & ~mask_d)) | watchdog_expired_flag_d; // [R12] [R13]

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl_o <= CTL_RESET;
			mask_q <= MASK_RESET;
			flag_q <= FLAG_RESET;
			live_prev_q <= '0;
			done_q <= 1'b0;
			watchdog_expired_flag_q <= 1'b0;
			init_q <= 2'h0;
			reg_rdata_o <= 8'h00;
			alert_b_o <= 1'b1;
		end else begin
			ctl_o <= ctl_d;
			mask_q <= mask_d;
			flag_q <= flag_d;
			live_prev_q <= live_w;
			done_q <= done_d;
			watchdog_expired_flag_q <= watchdog_expired_flag_d;
			init_q <= init_d;
			reg_rdata_o <= req_i.rd ? rdata_d : reg_rdata_o;
			alert_b_o <= !alert_d;
		end
	end

	// =====================================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	charge_wdt_clear_a: assert property (wdt_timeout_i |=> !ctl_o.charge_on) // [R1]
		else $error("charge stayed on after watchdog");
	role_readback_a: assert property ((req_i.rd && req_i.addr == CTL_ONE_OFS) // [R2]
		|=> reg_rdata_o[ROLE_LSB+:2] == $past(role_w))
		else $error("role readback wrong");
	freq_regrst_a: assert property (regrst_w |=> ctl_o.freq_offset_sel == FREQ_NOMINAL) // [R3]
		else $error("frequency field not reset");
	bus_prot_default_a: assert property (regrst_w // [R4]
		|=> ctl_o.bus_thermistor_prot_off == $past(master_w))
		else $error("bus thermistor default wrong");
	batt_prot_default_a: assert property (regrst_w // [R5]
		|=> ctl_o.batt_thermistor_prot_off == $past(master_w))
		else $error("battery thermistor default wrong");
	die_prot_default_a: assert property (regrst_w |=> !ctl_o.die_temp_prot_off) // [R6]
		else $error("die protection not reset");
	status_live_a: assert property ((req_i.rd && req_i.addr == STATUS_OFS) // [R7]
		|=> reg_rdata_o[7:1] == $past(live_w))
		else $error("status does not follow condition");
	done_cont_a: assert property (adc_continuous_i |=> !done_q ##0 !status_w[ADC_DONE_BIT]) // [R9]
		else $error("done high in continuous mode");
	flag_sticky_a: assert property ((set_w != 8'h00) // [R10]
		|=> (flag_q & $past(set_w)) == $past(set_w))
		else $error("event lost");
	flag_hold_a: assert property ((flag_q[1] && !rd_flag_w) |=> flag_q[1]) // [R10]
		else $error("flag cleared without read");
	done_flag_a: assert property ((adc_oneshot_done_i && adc_continuous_i && !flag_q[0]) // [R11]
		|=> !flag_q[0])
		else $error("done flag set in continuous mode");
	mask_wdt_keep_a: assert property (wdt_timeout_i && !req_i.wr |=> mask_q == $past(mask_q)) // [R12]
		else $error("mask changed on watchdog");
	alert_hold_a: assert property (((flag_q & ~mask_q) != 8'h00 && !rd_flag_w // [R13]
		&& !wr_mask_w) |=> !alert_b_o)
		else $error("alert missing for unmasked flag");
	alert_release_a: assert property ((flag_q == 8'h00 && !watchdog_expired_flag_q && set_w == 8'h00
		&& !wdt_timeout_i) |=> alert_b_o) // [R13]
		else $error("alert without cause");
	regrst_status_a: assert property (regrst_w && set_w == 8'h00 && !rd_flag_w // [R15]
		|=> flag_q == $past(flag_q) && mask_q == MASK_RESET)
		else $error("register reset touched flags or kept masks");
	watchdog_expired_flag_a: assert property (wdt_timeout_i |=> watchdog_expired_flag_q && !alert_b_o) // [R16]
		else $error("watchdog flag not raised");
	charge_regrst_a: assert property (regrst_w |=> !ctl_o.charge_on) // [R1] [R15]
		else $error("charge stayed on after register reset");
	init_default_a: assert property (init_load_w // [R4] [R5]
		|=> ctl_o.bus_thermistor_prot_off == $past(master_w)
		&& ctl_o.batt_thermistor_prot_off == $past(master_w))
		else $error("thermistor defaults not loaded from role");
	mask_write_a: assert property (wr_mask_w |=> mask_q == $past(req_i.wdata)) // [R12]
		else $error("mask write lost");
	flag_clear_a: assert property (rd_flag_w && set_w == 8'h00 |=> flag_q == 8'h00) // [R10]
		else $error("flags not cleared by read");

	flag_read_c: cover property (flag_q != 8'h00 ##1 rd_flag_w ##1 alert_b_o);
	oneshot_c: cover property (adc_oneshot_req_i ##[1:20] adc_oneshot_done_i);
	regrst_c: cover property (wr_mask_w ##[1:10] regrst_w);
	wdt_read_c: cover property (wdt_timeout_i ##[1:10] rd_ctl_w);
endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
	// clock and read data
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	// access strobes
	output charger_regs_pkg::reg_req_t req_o
);
	import charger_regs_pkg::*;
	// =====================================================================
	// access task
	initial req_o = '0;
	// strobe rises at a falling edge and drops after the taking edge;
	// addr and data go inverted so a stale value never looks valid
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		req_o = '{a, w, ~w, d};
		@(posedge clk_i);
		// read data is registered at the taking edge and settled by the next falling edge
		@(negedge clk_i);
		q = rdata_i;
		req_o = '{~a, 1'b0, 1'b0, ~d};
	endtask
endmodule

// File: testbench/charger_ctrl_alarm_irq_regs_tb_top.sv
`timescale 1ns/1ps
module charger_ctrl_alarm_irq_regs_tb_top;
	import charger_regs_pkg::*;
	// =====================================================================
	// signals
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	reg_req_t req;
	logic [7:0] rdata;
	logic [7:0] q;
	logic [4:0] alarm = '0;
	logic [1:0] attach = '0;
	logic [1:0] role = 2'h2;
	logic oreq = 1'b0;
	logic odone = 1'b0;
	logic cont = 1'b0;
	logic wdt = 1'b0;
	ctl_one_t ctl;
	logic alert_b;
	int fails = 0;
	int checked = 0;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	host_model host_model_i (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

	charger_ctrl_alarm_irq_regs charger_ctrl_alarm_irq_regs_i (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .reg_rdata_o(rdata),
		.alarm_live_i(alarm), .attach_live_i(attach), .role_select_i(role),
		.adc_oneshot_req_i(oreq), .adc_oneshot_done_i(odone),
		.adc_continuous_i(cont), .wdt_timeout_i(wdt), .ctl_o(ctl),
		.alert_b_o(alert_b)
	);

	// =====================================================================
	// tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_model_i.acc(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host_model_i.acc(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	task automatic pulse(ref logic s);
		cyc(1);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask

	task automatic wrap_up;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		repeat (12) @(negedge clk_i);
		rst_b_i = 1'b1;
		cyc(3);
		chk({2'h0, ctl}, 8'h06);
		chk({7'h0, alert_b}, 8'h01);
		rdchk(CTL_ONE_OFS, 8'h46);
		rdchk(MASKS_OFS, 8'h00);
		rdchk(FLAGS_OFS, 8'h00);
		wr(STATUS_OFS, 8'hff);
		rdchk(STATUS_OFS, 8'h00);
		wr(CTL_ONE_OFS, 8'h9d);
		chk({2'h0, ctl}, 8'h3d);
		rdchk(CTL_ONE_OFS, 8'hdd);
		for (int f = 0; f < 4; f++) begin
			wr(CTL_ONE_OFS, {3'h4, 2'(f), 3'h0});
			chk({6'h0, ctl.freq_offset_sel}, 8'(f));
		end
		pulse(wdt);
		cyc(1);
		chk({7'h0, ctl.charge_on}, 8'h00);
		chk({7'h0, alert_b}, 8'h00);
		rdchk(CHG_CTL_OFS, 8'h08);
		chk({7'h0, alert_b}, 8'h01);
		alarm = 5'h15;
		attach = 2'h3;
		cyc(4);
		chk({7'h0, alert_b}, 8'h00);
		rdchk(STATUS_OFS, 8'hae);
		rdchk(FLAGS_OFS, 8'hae);
		chk({7'h0, alert_b}, 8'h01);
		rdchk(FLAGS_OFS, 8'h00);
		alarm = 5'h0;
		attach = 2'h0;
		cyc(4);
		rdchk(STATUS_OFS, 8'h00);
		wr(MASKS_OFS, 8'h80);
		alarm = 5'h10;
		cyc(4);
		chk({7'h0, alert_b}, 8'h01);
		rdchk(FLAGS_OFS, 8'h80);
		pulse(wdt);
		rdchk(MASKS_OFS, 8'h80);
		rdchk(CHG_CTL_OFS, 8'h08);
		alarm = 5'h0;
		pulse(oreq);
		pulse(odone);
		cyc(1);
		chk({7'h0, alert_b}, 8'h00);
		rdchk(STATUS_OFS, 8'h01);
		rdchk(FLAGS_OFS, 8'h01);
		pulse(oreq);
		rdchk(STATUS_OFS, 8'h00);
		cont = 1'b1;
		pulse(odone);
		cyc(1);
		rdchk(STATUS_OFS, 8'h00);
		rdchk(FLAGS_OFS, 8'h00);
		cont = 1'b0;
		role = 2'h1;
		cyc(3);
		rdchk(CTL_ONE_OFS, 8'h38);
		role = 2'h2;
		cyc(3);
		wr(CTL_ONE_OFS, 8'h9d);
		wr(CHG_CTL_OFS, 8'h80);
		cyc(1);
		chk({2'h0, ctl}, 8'h06);
		rdchk(MASKS_OFS, 8'h00);
		wrap_up();
	end

	// a hang far past the expected run of about a hundred and ten cycles counts as a mismatch
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule
